// *** rtl/pcsia_core.sv ***
`timescale 1ns/1ns
// Program counter, return stack and indirect data addressing
module pcsia_core
  import pcsia_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pcsia_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic fetch_step,
  input wire logic jump_instruction,
  input wire logic call_instruction,
  input wire logic return_plain,
  input wire logic return_with_literal,
  input wire logic return_from_interrupt,
  input wire logic irq_vector,
  input wire logic [pcsia_pkg::TGT_W-1:0] branch_target,
  output logic [pcsia_pkg::PC_W-1:0] pc,
  output logic [pcsia_pkg::DADDR_W-1:0] data_addr,
  output logic [7:0] data_wdata,
  output logic data_we,
  input wire logic [7:0] data_rdata
);
  import pcsia_pkg::*;

  // Address match on the software port, used by the write decodes; reads decode reg_addr directly
  function automatic logic hit(
    input logic [RADDR_W-1:0] addr,
    input logic [RADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // Software-visible state
  logic [LATCH_W-1:0] pc_high_holding_latch; // Feeds upper counter bits
  logic [7:0] indirect_pointer; // Low eight bits of indirect address
  logic indirect_bank_bit; // Ninth indirect address bit

  // Counter datapath
  logic [PC_W-1:0] next_pc; // Value loaded at the next edge
  logic [PC_W-1:0] pc_plus_one; // Sequential successor
  logic [PC_W-1:0] branch_addr; // Jump and call destination
  logic [PC_W-1:0] stack_top; // Entry a return would pop
  logic [PC_W-1:0] push_value; // Entry a push would store
  logic any_return; // One of the three return kinds
  logic low_write; // Software write to the counter low byte
  logic stack_push; // Call or interrupt branch
  logic stack_pop; // Any return
  pcsia_load_e load_kind; // Chosen source for next_pc

  assign pc_plus_one = pc + 13'h0001;
  assign any_return = return_plain | return_with_literal
                    | return_from_interrupt;
  assign low_write = reg_wr && hit(reg_addr, OFS_PC_LOW);

  // Page bits would sit above the target; this variant forces zero
  assign branch_addr = {(PAGE_SELECT_EN ? pc_high_holding_latch[PAGE_HI:PAGE_LO] : 2'b00),
                        branch_target};

  // Choose the load source; the interrupt wins because it abandons
  // whatever the decoder was doing in that cycle
  always_comb
  begin
    if (irq_vector)
    begin
      load_kind = PCSIA_LD_IRQ;
    end
    else if (any_return)
    begin
      load_kind = PCSIA_LD_RET;
    end
    else if (call_instruction)
    begin
      load_kind = PCSIA_LD_CALL;
    end
    else if (jump_instruction)
    begin
      load_kind = PCSIA_LD_JUMP;
    end
    else if (low_write)
    begin
      load_kind = PCSIA_LD_LOW;
    end
    else if (fetch_step)
    begin
      load_kind = PCSIA_LD_STEP;
    end
    else
    begin
      load_kind = PCSIA_LD_HOLD;
    end
  end

  // Stack traffic follows the chosen load only
  assign stack_push = (load_kind == PCSIA_LD_IRQ) || (load_kind == PCSIA_LD_CALL);
  assign stack_pop = (load_kind == PCSIA_LD_RET);

  // An interrupt saves the counter of the abandoned instruction;
  // a call saves the address after itself
  assign push_value = (load_kind == PCSIA_LD_IRQ) ? pc : pc_plus_one;

  // Next counter value per load kind
  always_comb
  begin
    case (load_kind)
      PCSIA_LD_IRQ:
      begin
        next_pc = IRQ_VECTOR;
      end
      PCSIA_LD_RET:
      begin
        next_pc = stack_top;
      end
      PCSIA_LD_CALL, PCSIA_LD_JUMP:
      begin
        next_pc = branch_addr;
      end
      PCSIA_LD_LOW:
      begin
        // Whole latch goes up with the written byte
        next_pc = {pc_high_holding_latch, reg_wdata};
      end
      PCSIA_LD_STEP:
      begin
        next_pc = pc_plus_one;
      end
      default:
      begin
        next_pc = pc;
      end
    endcase
  end

  // Counter register, 13 bits wide
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= PC_RESET;
    end
    else
    begin
      pc <= next_pc;
    end
  end

  // Return stack; full counter width is stored
  pcsia_stack u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .push(stack_push),
    .pop(stack_pop),
    .push_data(push_value),
    .top(stack_top)
  );

  // Holding latch changes only by software write, never by stack traffic
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_high_holding_latch <= LATCH_RESET;
    end
    else if (reg_wr && hit(reg_addr, OFS_LATCH))
    begin
      // Page bits stay writable storage even though ignored
      pc_high_holding_latch <= reg_wdata[LATCH_W-1:0];
    end
  end

  // Pointer register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      indirect_pointer <= POINTER_RESET;
    end
    else if (reg_wr && hit(reg_addr, OFS_POINTER))
    begin
      indirect_pointer <= reg_wdata;
    end
  end

  // Bank bit; other status bits belong to the arithmetic unit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      indirect_bank_bit <= BANK_RESET;
    end
    else if (reg_wr && hit(reg_addr, OFS_STATUS))
    begin
      indirect_bank_bit <= reg_wdata[BANK_BIT_POS];
    end
  end

  // Effective address is loaded from the pending pointer and bank, so it
  // moves at the same edge as they do; the next port access sees the new target
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_addr <= {BANK_RESET, POINTER_RESET};
    end
    else
    begin
      data_addr <= {next_bank(), next_pointer()};
    end
  end

  // Pending pointer value, seen by the address register above
  function automatic logic [7:0] next_pointer();
    next_pointer = (reg_wr && hit(reg_addr, OFS_POINTER)) ? reg_wdata : indirect_pointer;
  endfunction : next_pointer

  // Pending bank value
  function automatic logic next_bank();
    next_bank = (reg_wr && hit(reg_addr, OFS_STATUS)) ? reg_wdata[BANK_BIT_POS]
                                                       : indirect_bank_bit;
  endfunction : next_bank

  // Writes to the indirect port go to the pointed register, not here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_we <= 1'b0;
      data_wdata <= 8'h00;
    end
    else
    begin
      data_we <= reg_wr && hit(reg_addr, OFS_INDIRECT);
      if (reg_wr && hit(reg_addr, OFS_INDIRECT))
      begin
        data_wdata <= reg_wdata;
      end
    end
  end

  // Read data stand for one cycle only; unmapped offsets answer zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= RDATA_IDLE;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= RDATA_IDLE;
    end
    else
    begin
      case (reg_addr)
        OFS_PC_LOW:
        begin
          reg_rdata <= pc[7:0];
        end
        OFS_LATCH:
        begin
          // Latch reads back; upper counter bits never do
          reg_rdata <= {3'h0, pc_high_holding_latch};
        end
        OFS_POINTER:
        begin
          reg_rdata <= indirect_pointer;
        end
        OFS_STATUS:
        begin
          reg_rdata <= {indirect_bank_bit, 7'h00};
        end
        OFS_INDIRECT:
        begin
          // Data file answers combinationally at data_addr
          reg_rdata <= data_rdata;
        end
        default:
        begin
          reg_rdata <= RDATA_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Quiet when no interrupt, return, call or jump pulse is present; fetch step and bus strobes may be active
  logic quiet_instr;
  assign quiet_instr = !irq_vector && !any_return && !call_instruction
                     && !jump_instruction;

  low_write_load_a: assert property (
    reg_wr && reg_addr == OFS_PC_LOW && quiet_instr
    |=> pc == {$past(pc_high_holding_latch), $past(reg_wdata)})
    else $error("low byte write did not load latch and byte");

  jump_target_a: assert property (
    jump_instruction && !call_instruction && !any_return && !irq_vector
    |=> pc == {2'b00, $past(branch_target)})
    else $error("jump did not land on page-zero target");

  call_return_a: assert property (
    call_instruction && !any_return && !irq_vector ##1
    any_return && !irq_vector |=> pc == 13'($past(pc, 2) + 13'h0001))
    else $error("return after call missed call address plus one");

  irq_return_a: assert property (
    irq_vector ##1 return_from_interrupt && !irq_vector
    |=> pc == $past(pc, 2))
    else $error("interrupt return did not restore counter");

  latch_hold_a: assert property (
    (stack_push || stack_pop) && !(reg_wr && reg_addr == OFS_LATCH)
    |=> $stable(pc_high_holding_latch))
    else $error("stack traffic disturbed holding latch");

  fetch_step_a: assert property (
    fetch_step && quiet_instr && !(reg_wr && reg_addr == OFS_PC_LOW)
    |=> pc == 13'($past(pc) + 13'h0001))
    else $error("sequential fetch did not advance by one");

  bank_address_a: assert property (
    !reg_wr ##1 !reg_wr |-> data_addr == {indirect_bank_bit, indirect_pointer})
    else $error("effective address lost bank bit or pointer");

  indirect_write_a: assert property (
    reg_wr && reg_addr == OFS_INDIRECT
    |=> data_we && data_wdata == $past(reg_wdata)
        ##1 (!data_we || $past(reg_wr && reg_addr == OFS_INDIRECT)))
    else $error("indirect write not redirected to data file");

  latch_read_a: assert property (
    reg_rd && reg_addr == OFS_LATCH
    |=> reg_rdata == {3'h0, $past(pc_high_holding_latch)})
    else $error("latch readback wrong");
endmodule : pcsia_core

// *** shared/pcsia_pkg.sv ***
// How it works
// - 13-bit counter, low byte software visible
// - Upper five bits only via holding latch
// - Low byte write loads upper from latch
// - Jump/call: 11-bit target plus page bits
// - Call or interrupt pushes full counter
// - All three returns pop into counter
// - Eight by 13 stack, hidden pointer
// - Stack wraps, ninth push overwrites first
// - No overflow or underflow status
// - Push and pop leave latch unchanged
// - This variant ignores the page bits
// - Indirect port redirects to pointed register
// - Effective address is bank bit over pointer
package pcsia_pkg;
  // Widths
  localparam int PC_W = 13;
  localparam int TGT_W = 11;
  localparam int LATCH_W = 5;
  localparam int DADDR_W = 9;
  localparam int RADDR_W = 3;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  // Register offsets on the software port
  localparam logic [RADDR_W-1:0] OFS_PC_LOW = 3'h0;
  localparam logic [RADDR_W-1:0] OFS_LATCH = 3'h1;
  localparam logic [RADDR_W-1:0] OFS_POINTER = 3'h2;
  localparam logic [RADDR_W-1:0] OFS_STATUS = 3'h3;
  localparam logic [RADDR_W-1:0] OFS_INDIRECT = 3'h4;
  // Field positions
  localparam int BANK_BIT_POS = 7;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  // Page bits take no part in branch targets on this variant
  localparam logic PAGE_SELECT_EN = 1'b0;
  // Reset values and the interrupt vector
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic BANK_RESET = 1'b0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // Kinds of counter load; HOLD when none, then IRQ down to STEP in order of priority
  typedef enum logic [2:0] {
    PCSIA_LD_HOLD = 3'b000,
    PCSIA_LD_IRQ = 3'b001,
    PCSIA_LD_RET = 3'b010,
    PCSIA_LD_CALL = 3'b011,
    PCSIA_LD_JUMP = 3'b100,
    PCSIA_LD_LOW = 3'b101,
    PCSIA_LD_STEP = 3'b110
  } pcsia_load_e;
endpackage : pcsia_pkg

// *** rtl/pcsia_stack.sv ***
`timescale 1ns/1ns
// Eight-entry circular return stack
module pcsia_stack
  import pcsia_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [pcsia_pkg::PC_W-1:0] push_data,
  output logic [pcsia_pkg::PC_W-1:0] top
);
  import pcsia_pkg::*;

  // Entries live outside program and data space
  logic [PC_W-1:0] mem [STK_DEPTH];
  // Next free slot; no port reads or writes it
  logic [STK_PTR_W-1:0] ptr;
  logic [STK_PTR_W-1:0] ptr_below;

  assign ptr_below = ptr - 3'h1;
  // Top entry sits just below the free slot
  assign top = mem[ptr_below];

  // Pointer wraps modulo eight on both ends
  // No flag on overflow or underflow, by design
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr <= 3'h0;
    end
    else if (push)
    begin
      ptr <= ptr + 3'h1;
    end
    else if (pop)
    begin
      ptr <= ptr_below;
    end
  end

  // Ninth push lands on the first push's slot
  // Entries are not reset; stale values after underflow are expected
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[ptr] <= push_data;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  stack_wrap_a: assert property (
    push |=> ptr == 3'($past(ptr) + 3'h1) && top == $past(push_data))
    else $error("stack push did not advance and store");
  stack_pop_a: assert property (
    pop && !push |=> ptr == 3'($past(ptr) - 3'h1))
    else $error("stack pop did not step pointer back");
endmodule : pcsia_stack

// *** test/pcsia_data_file_model.sv ***
`timescale 1ns/1ns
// Data register file seen by the core through the indirect window
module pcsia_data_file_model
  import pcsia_pkg::*;
(
  input wire logic clk,
  input wire logic [pcsia_pkg::DADDR_W-1:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  output logic [7:0] data_rdata
);
  // Full 9-bit space so the two banks never alias
  logic [7:0] mem [0:511];
  // Combinational read; unwritten cells read unknown, so the bench only reads what it wrote
  assign data_rdata = mem[data_addr];
  // Write on the core's registered strobe
  always_ff @(posedge clk)
  begin
    if (data_we)
    begin
      mem[data_addr] <= data_wdata;
    end
  end
endmodule : pcsia_data_file_model

// *** test/tb_top.sv ***
`timescale 1ns/1ns
// Bench for the counter, return stack and indirect addressing
module tb_top;
  import pcsia_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // Decoder pulses: 0 step, 1 jump, 2 call, 3..5 returns, 6 interrupt
  logic [6:0] dec = 7'h00;
  logic [10:0] branch_target = 11'h000;
  logic [7:0] reg_rdata;
  logic [7:0] data_wdata;
  logic [7:0] data_rdata;
  logic [12:0] pc;
  logic [8:0] data_addr;
  logic data_we;
  logic [7:0] rd;
  logic [10:0] tgt;
  logic [7:0] seed = 8'h54;
  int failures = 0;
  int check_count = 0;
  // Reference state kept with plain integers
  int m_pc = 0;
  int m_sp = 0;
  int m_latch = 0;
  int m_ptr = 0;
  int m_bank = 0;
  int m_stk [8];

  // Clock of 40 ns
  always #20 clk = ~clk;

  pcsia_core i_pcsia_core (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_step(dec[0]), .jump_instruction(dec[1]), .call_instruction(dec[2]),
    .return_plain(dec[3]), .return_with_literal(dec[4]),
    .return_from_interrupt(dec[5]), .irq_vector(dec[6]),
    .branch_target(branch_target), .pc(pc), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata)
  );

  pcsia_data_file_model i_pcsia_data_file_model (
    .clk(clk), .data_addr(data_addr), .data_wdata(data_wdata),
    .data_we(data_we), .data_rdata(data_rdata)
  );

  // Eight-bit shift register for stimulus
  function logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Random branch target from two steps of the shift register
  task next_tgt();
    seed = lfsr(seed);
    tgt[10:3] = seed;
    seed = lfsr(seed);
    tgt[2:0] = seed[2:0];
  endtask : next_tgt

  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Expected read data per offset; unmapped offsets read zero
  function logic [7:0] exp_read(input int a);
    case (a)
      0: exp_read = m_pc[7:0];
      1: exp_read = m_latch[7:0];
      2: exp_read = m_ptr[7:0];
      3: exp_read = {m_bank[0], 7'h00};
      default: exp_read = 8'h00;
    endcase
  endfunction : exp_read

  // One-cycle write, reference updated at the taking edge
  task reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    case (a)
      3'h0: m_pc = m_latch * 256 + d;
      3'h1: m_latch = d & 8'h1f;
      3'h2: m_ptr = d;
      3'h3: m_bank = d[7];
      default: ;
    endcase
  endtask : reg_write

  // One-cycle read; data sampled in the single cycle it stands
  task reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Reference effect of one decoder pulse, same priority as the core
  task model_pulse(input logic [6:0] m, input logic [10:0] t);
    if (m[6])
    begin
      m_stk[m_sp] = m_pc;
      m_sp = (m_sp + 1) % 8;
      m_pc = IRQ_VECTOR;
    end
    else if (|m[5:3])
    begin
      m_sp = (m_sp + 7) % 8;
      m_pc = m_stk[m_sp];
    end
    else if (m[2])
    begin
      m_stk[m_sp] = (m_pc + 1) % 8192;
      m_sp = (m_sp + 1) % 8;
      m_pc = t;
    end
    else if (m[1])
      m_pc = t;
    else if (m[0])
      m_pc = (m_pc + 1) % 8192;
  endtask : model_pulse

  // Decoder pulse, then pc compared with the reference
  task pulse(input logic [6:0] m, input logic [10:0] t);
    @(posedge clk);
    dec <= m;
    branch_target <= t;
    @(posedge clk);
    dec <= 7'h00;
    #1;
    model_pulse(m, t);
    check(16'(pc), m_pc[15:0]);
  endtask : pulse

  // Two decoder pulses on consecutive edges, pc compared after each
  task pulse_pair(input logic [6:0] m1, input logic [10:0] t1,
                  input logic [6:0] m2, input logic [10:0] t2);
    @(posedge clk);
    dec <= m1;
    branch_target <= t1;
    @(posedge clk);
    dec <= m2;
    branch_target <= t2;
    #1;
    model_pulse(m1, t1);
    check(16'(pc), m_pc[15:0]);
    @(posedge clk);
    dec <= 7'h00;
    #1;
    model_pulse(m2, t2);
    check(16'(pc), m_pc[15:0]);
  endtask : pulse_pair

  // Single exit for the run
  task test_done();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Cuts a hang short; the sequence needs well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(16'(pc), 16'h0000);
    // Reset values and unmapped offsets
    for (int a = 0; a < 8; a++)
    begin
      if (a != 4)
      begin
        reg_read(a[2:0], rd);
        check(16'(rd), 16'(exp_read(a)));
      end
    end
    // Upper latch bits 7:5 do not exist
    reg_write(OFS_LATCH, 8'hff);
    reg_read(OFS_LATCH, rd);
    check(16'(rd), 16'h001f);
    // Low byte write pulls the upper bits from the latch
    reg_write(OFS_PC_LOW, 8'hff);
    check(16'(pc), m_pc[15:0]);
    reg_read(OFS_PC_LOW, rd);
    check(16'(rd), 16'(exp_read(0)));
    // Step off the top of the space, across a 256 boundary
    pulse(7'h01, 11'h000);
    // Page bits are set in the latch yet ignored by the jump
    next_tgt();
    pulse(7'h02, tgt);
    // Call beats jump and step in the same cycle
    next_tgt();
    pulse(7'h07, tgt);
    // Ten calls wrap the eight-deep stack, ten returns of all kinds
    for (int i = 0; i < 10; i++)
    begin
      next_tgt();
      pulse(7'h04, tgt);
    end
    for (int i = 0; i < 10; i++)
    begin
      pulse(7'h08 << (i % 3), 11'h000);
    end
    reg_read(OFS_LATCH, rd);
    check(16'(rd), 16'h001f);
    // Interrupt pushes the counter itself, then returns to it
    pulse(7'h40, 11'h000);
    pulse(7'h20, 11'h000);
    // Return straight after a call or an interrupt, no idle cycle between
    next_tgt();
    pulse_pair(7'h04, tgt, 7'h10, 11'h000);
    pulse_pair(7'h40, 11'h000, 7'h20, 11'h000);
    // Indirect access in both banks
    for (int b = 0; b < 2; b++)
    begin
      seed = lfsr(seed);
      reg_write(OFS_POINTER, seed);
      reg_write(OFS_STATUS, b[0] ? 8'hff : 8'h7f);
      check(16'(data_addr), 16'(m_bank * 256 + m_ptr));
      seed = lfsr(seed);
      reg_write(OFS_INDIRECT, seed);
      check(16'({data_we, data_wdata}), 16'({1'b1, seed}));
      reg_read(OFS_INDIRECT, rd);
      check(16'(rd), 16'(seed));
      reg_read(OFS_STATUS, rd);
      check(16'(rd), 16'(exp_read(3)));
    end
    test_done();
  end
endmodule : tb_top
